// ==== shared/slfbm_defs.svh ====
// Register offsets, field positions and reset values of the lane monitor
`ifndef SLFBM_DEFS_SVH
`define SLFBM_DEFS_SVH
`define SLFBM_ADDR_W 9
`define SLFBM_OFS_TEST_CTRL 9'h1a0
`define SLFBM_OFS_ERR_CNT 9'h1b0
`define SLFBM_OFS_PTR_SPACING 9'h170
`define SLFBM_OFS_LANE_ERR 9'h160
`define SLFBM_OFS_LANE_MODE 9'h1c8
`define SLFBM_OFS_PATTERN_SEL 9'h1c9
`define SLFBM_BIT_ERR_EN 0
`define SLFBM_BIT_GB_FLAG 0
`define SLFBM_RST_TEST_CTRL 8'h00
`define SLFBM_SPACING_MAX_8B10B 5'h0e
`define SLFBM_SPACING_MAX_64B66B 5'h10
`define SLFBM_CNT_SAT 8'hff
`define SLFBM_PRBS_SEED 7'h7f
`define SLFBM_LOCK_BITS 4'h7
`endif

// ==== shared/slfbm_pkg.sv ====
// Types shared by both ends of the lane monitor
package slfbm_pkg;
  typedef logic [15:0] slfbm_lane_mask_t;
endpackage

// ==== shared/slfbm_link_if.sv ====
// Serial lane link between the pattern sender and the lane monitor
`timescale 1ns/1ps
interface slfbm_link_if #(parameter int LANES = 16);
  logic [LANES-1:0] lane_bit;
  logic [LANES-1:0] lane_valid;
  logic [LANES-1:0][4:0] fill_level;
  modport sender (output lane_bit, output lane_valid, output fill_level);
  modport monitor (input lane_bit, input lane_valid, input fill_level);
endinterface

// ==== src/slfbm_pattern_tx.sv ====
// Transmit end: sends PRBS7 on each enabled lane and models the gearbox fill
`timescale 1ns/1ps
`include "slfbm_defs.svh"
module slfbm_pattern_tx import slfbm_pkg::*; #(
  parameter int LANES = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic link_enable_i,
  input wire logic link_test_pattern_select_i,
  input wire logic [LANES-1:0] lane_on_i,
  input wire logic [LANES-1:0] inject_error_i,
  input wire logic [LANES-1:0][4:0] fill_level_i,
  slfbm_link_if.sender link
);
  initial begin
    if (LANES < 1 || LANES > 16) $error("LANES out of range");
  end
  typedef struct packed {
    logic [6:0] lfsr;
    logic [LANES-1:0] bits;
    logic [LANES-1:0] valid;
    logic [LANES-1:0][4:0] fill;
  } slfbm_tx_s;
  slfbm_tx_s st;
  slfbm_tx_s next_st;
  logic active;
  assign active = link_enable_i && link_test_pattern_select_i;
  always_comb begin
    next_st = st;
    next_st.fill = fill_level_i;
    if (active) begin
      next_st.lfsr = {st.lfsr[5:0], st.lfsr[6] ^ st.lfsr[5]};
    end
    next_st.valid = active ? lane_on_i : '0;
    for (int i = 0; i < LANES; i++) begin
      next_st.bits[i] = (st.lfsr[6] ^ st.lfsr[5]) ^ inject_error_i[i];
    end
    if (sys_rst_i) begin
      next_st = '0;
      next_st.lfsr = `SLFBM_PRBS_SEED;
    end
  end
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end
  assign link.lane_bit = st.bits;
  assign link.lane_valid = st.valid;
  assign link.fill_level = st.fill;
endmodule // slfbm_pattern_tx

// ==== src/slfbm_lane_monitor.sv ====
// Receive end: gearbox pointer spacing, sticky flags and PRBS error counters
//
// Contract
// RULE1: Report 5-bit write/read pointer spacing per lane
// RULE2: Spacing spans 0-14 (8b/10b), 0-16 (64b/66b)
// RULE3: End-of-range spacing sets lane gearbox error flag
// RULE4: Spacing 1 setup margin, max-1 hold margin
// RULE5: Spacing measured in read clock, half-period steps
// RULE6: 8b/10b step 20 UI, last 380 UI
// RULE7: 64b/66b step 16.5 UI, last 412.5 UI
// RULE8: Spacing of disabled or extra lanes undefined
// RULE9: Control bit 0 enables counters, resets zero
// RULE10: Configure, select pattern, enable link, then count
// RULE11: Enable 0 then 1 clears and restarts
// RULE12: Checker self-syncs to PRBS after enable rise
// RULE13: Eight-bit per-lane error count saturates at 255
// RULE14: Counters at consecutive addresses, lane 0 lowest
// RULE15: Counts of disabled or extra lanes undefined
// RULE16: Gearbox fault sets sticky flag, write-1 clears
// RULE17: Count mismatching bits while enabled, hold otherwise
// RULE18: Spacing sampled continuously for coherent reads
`timescale 1ns/1ps
`include "slfbm_defs.svh"
module slfbm_lane_monitor import slfbm_pkg::*; #(
  parameter int LANES = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [`SLFBM_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic count_enable_o,
  slfbm_link_if.monitor link
);
  initial begin
    if (LANES < 1 || LANES > 16) $error("LANES out of range");
  end
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic err_en;
    logic [LANES-1:0] mode_64b66b;
    logic [LANES-1:0][4:0] spacing;
    logic [LANES-1:0] gb_flag;
    logic [LANES-1:0][7:0] err_cnt;
    logic [LANES-1:0][6:0] ref_lfsr;
    logic [LANES-1:0][3:0] lock_cnt;
    logic [7:0] rdata;
  } slfbm_mon_s;
  slfbm_mon_s st;
  slfbm_mon_s next_st;
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [4:0] top;
    logic [4:0] lvl;
    logic exp_bit;
    logic [3:0] idx;
    logic en_rise;
    en_rise = 1'b0;
    top = '0;
    lvl = '0;
    exp_bit = 1'b0;
    idx = '0;
    next_st = st;
    next_st.rdata = 8'h00;
    // Register writes
    if (wr_i) begin
      if (addr_i == `SLFBM_OFS_TEST_CTRL) begin
        next_st.err_en = wdata_i[`SLFBM_BIT_ERR_EN]; // RULE9
      end
      if (addr_i == `SLFBM_OFS_LANE_MODE) begin
        next_st.mode_64b66b = LANES'(wdata_i);
      end
      if (addr_i[8:4] == `SLFBM_OFS_LANE_ERR >> 4 && 32'(addr_i[3:0]) < LANES &&
          wdata_i[`SLFBM_BIT_GB_FLAG]) begin
        next_st.gb_flag[addr_i[3:0]] = 1'b0; // RULE16
      end
    end
    // Enable rise taken from the value being written, not a loop through next state
    en_rise = next_st.err_en && !st.err_en; // RULE11
    for (int i = 0; i < LANES; i++) begin
      // Spacing sampled every read-clock cycle
      lvl = link.fill_level[i];
      top = st.mode_64b66b[i] ? `SLFBM_SPACING_MAX_64B66B : `SLFBM_SPACING_MAX_8B10B; // RULE2 RULE6 RULE7
      if (lvl > top) begin
        lvl = top;
      end
      next_st.spacing[i] = lvl; // RULE1 RULE5 RULE18 RULE4
      if (lvl == 5'h00 || lvl == top) begin
        next_st.gb_flag[i] = 1'b1; // RULE3 RULE16
      end
      // PRBS checker: reload from data, then lock and compare
      exp_bit = st.ref_lfsr[i][6] ^ st.ref_lfsr[i][5];
      if (en_rise) begin
        next_st.err_cnt[i] = 8'h00; // RULE11
        next_st.lock_cnt[i] = 4'h0; // RULE12
      end else if (st.err_en && link.lane_valid[i]) begin
        if (st.lock_cnt[i] < `SLFBM_LOCK_BITS) begin
          next_st.ref_lfsr[i] = {st.ref_lfsr[i][5:0], link.lane_bit[i]}; // RULE12
          next_st.lock_cnt[i] = st.lock_cnt[i] + 4'h1;
        end else begin
          next_st.ref_lfsr[i] = {st.ref_lfsr[i][5:0], exp_bit};
          if (link.lane_bit[i] != exp_bit && st.err_cnt[i] != `SLFBM_CNT_SAT) begin
            next_st.err_cnt[i] = st.err_cnt[i] + 8'h01; // RULE17 RULE13
          end
        end
      end
    end
    // Register reads, data one cycle later
    if (rd_i) begin
      idx = addr_i[3:0];
      if (addr_i == `SLFBM_OFS_TEST_CTRL) begin
        next_st.rdata = {7'h00, st.err_en};
      end else if (addr_i == `SLFBM_OFS_LANE_MODE) begin
        next_st.rdata = 8'(st.mode_64b66b);
      end else if (32'(idx) < LANES) begin
        if (addr_i[8:4] == `SLFBM_OFS_ERR_CNT >> 4) begin
          next_st.rdata = st.err_cnt[idx]; // RULE14 RULE15
        end else if (addr_i[8:4] == `SLFBM_OFS_PTR_SPACING >> 4) begin
          next_st.rdata = {3'h0, st.spacing[idx]}; // RULE8
        end else if (addr_i[8:4] == `SLFBM_OFS_LANE_ERR >> 4) begin
          next_st.rdata = {7'h00, st.gb_flag[idx]};
        end
      end
    end
    if (sys_rst_i) begin
      next_st = '0;
      next_st.err_en = 1'(`SLFBM_RST_TEST_CTRL); // RULE9
    end
  end
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end
  assign rdata_o = st.rdata;
  assign count_enable_o = st.err_en; // RULE10
endmodule // slfbm_lane_monitor

// ==== dv/slfbm_lane_monitor_properties.sv ====
// Checker for the lane monitor register port and the lane 0 link fill level
`timescale 1ns/1ps
`include "slfbm_defs.svh"
module slfbm_lane_monitor_properties (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [`SLFBM_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic count_enable_o,
  input wire logic [15:0][4:0] fill_level
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_ctrl_wr;
    wr_i && addr_i == `SLFBM_OFS_TEST_CTRL;
  endsequence
  property p_en_set;
    s_ctrl_wr |=> count_enable_o == $past(wdata_i[`SLFBM_BIT_ERR_EN]);
  endproperty
  property p_en_hold;
    !(wr_i && addr_i == `SLFBM_OFS_TEST_CTRL) |=> $stable(count_enable_o);
  endproperty
  property p_ctrl_rd;
    rd_i && addr_i == `SLFBM_OFS_TEST_CTRL |=> rdata_o == {7'h00, count_enable_o};
  endproperty
  property p_sp_rd;
    rd_i && addr_i[8:4] == 5'h17 |=> rdata_o[7:5] == 3'h0;
  endproperty
  property p_flag_rd;
    rd_i && addr_i[8:4] == 5'h16 |=> rdata_o[7:1] == 7'h00;
  endproperty
  property p_fill_max;
    fill_level[0] <= `SLFBM_SPACING_MAX_64B66B;
  endproperty
  a_en_set: assert property (p_en_set) else $error("enable bit not taken");
  a_en_hold: assert property (p_en_hold) else $error("enable changed unasked");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read wrong");
  a_sp_rd: assert property (p_sp_rd) else $error("spacing wider than five bits");
  a_fill_max: assert property (p_fill_max) else $error("fill out of range");
  a_flag_rd: assert property (p_flag_rd) else $error("flag read wider than one bit");
endmodule // slfbm_lane_monitor_properties

// ==== dv/serdes_lane_fifo_and_ber_monitor_bench.sv ====
// Bench joining pattern sender and lane monitor
`timescale 1ns/1ps
`include "slfbm_defs.svh"
module serdes_lane_fifo_and_ber_monitor_bench;
  import slfbm_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, link_en = 0, pat_sel = 0;
  logic [8:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o;
  logic count_enable_o;
  slfbm_lane_mask_t lane_on = 0, inj = 0;
  logic [15:0][4:0] fill = 0;
  logic [7:0] sp [6] = '{8'h05, 8'h0e, 8'h00, 8'h10, 8'h0e, 8'h0e};
  logic [7:0] fl [6] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
  int miscompares = 0, num_checks = 0;
  slfbm_link_if i_slfbm_link_if ();
  slfbm_pattern_tx i_slfbm_pattern_tx (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_enable_i(link_en),
    .link_test_pattern_select_i(pat_sel), .lane_on_i(lane_on), .inject_error_i(inj), .fill_level_i(fill),
    .link(i_slfbm_link_if.sender));
  slfbm_lane_monitor i_slfbm_lane_monitor (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .count_enable_o(count_enable_o),
    .link(i_slfbm_link_if.monitor));
  slfbm_lane_monitor_properties i_slfbm_lane_monitor_properties (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .count_enable_o(count_enable_o), .fill_level(i_slfbm_link_if.fill_level));
  // ----------------------------------------
  // Tasks and tests
  // ----------------------------------------
  initial forever #4 clk_i = ~clk_i;
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    #1;
    num_checks++;
    if (rdata_o !== e) begin
      miscompares++;
      $display("unexpected rdata at %h: expected %h, seen %h", a, e, rdata_o);
    end
  endtask
  task automatic pulse(input int n);
    @(posedge clk_i);
    inj[n] <= 1;
    @(posedge clk_i);
    inj[n] <= 0;
    idle(5);
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    idle(3);
    sys_rst_i <= 0;
    rd(`SLFBM_OFS_TEST_CTRL, `SLFBM_RST_TEST_CTRL);
    rd(9'h1f0, 8'h00);
    lane_on <= 16'hffff;
    fill[0] <= 5'h05;
    fill[1] <= 5'h0e;
    fill[3] <= `SLFBM_SPACING_MAX_64B66B;
    fill[4] <= 5'h10;
    fill[5] <= 5'h0e;
    wr(`SLFBM_OFS_LANE_MODE, 8'h28);
    idle(4);
    wr(`SLFBM_OFS_LANE_ERR, 8'h01);
    wr(`SLFBM_OFS_LANE_ERR + 9'h005, 8'h01);
    for (int n = 0; n < 6; n++) begin
      rd(9'(`SLFBM_OFS_PTR_SPACING + n), sp[n]);
      rd(9'(`SLFBM_OFS_LANE_ERR + n), fl[n]);
    end
    fill[1] <= 5'h07;
    idle(4);
    wr(`SLFBM_OFS_LANE_ERR + 9'h001, 8'h01);
    rd(`SLFBM_OFS_LANE_ERR + 9'h001, 8'h00);
    wr(`SLFBM_OFS_LANE_ERR + 9'h002, 8'h01);
    rd(`SLFBM_OFS_LANE_ERR + 9'h002, 8'h01);
    link_en <= 1;
    pat_sel <= 1;
    wr(`SLFBM_OFS_TEST_CTRL, 8'h01);
    idle(20);
    rd(`SLFBM_OFS_ERR_CNT, 8'h00);
    pulse(0);
    rd(`SLFBM_OFS_ERR_CNT, 8'h01);
    wr(`SLFBM_OFS_TEST_CTRL, 8'h00);
    pulse(0);
    rd(`SLFBM_OFS_ERR_CNT, 8'h01);
    wr(`SLFBM_OFS_TEST_CTRL, 8'h01);
    idle(20);
    rd(`SLFBM_OFS_ERR_CNT, 8'h00);
    inj[2] <= 1;
    idle(300);
    inj[2] <= 0;
    rd(`SLFBM_OFS_ERR_CNT + 9'h002, `SLFBM_CNT_SAT);
    rd(`SLFBM_OFS_ERR_CNT + 9'h001, 8'h00);
    tally_and_finish();
  end
endmodule // serdes_lane_fifo_and_ber_monitor_bench
